// ===== rtl/adc_host_interface.sv
// Behaviour
// - parallel read drives result, line0 lsb
// - in parallel mode data lines driven only under select and read; serial mode drives the output line while rx frame is low
// - coding bit picks two's complement or binary
// - parallel write stores three channel bits
// - parallel write stores soft start bit
// - parallel write stores standby bit
// - parallel write stores coding bit
// - serial mode reuses five data lines
// - tx frame low before serial input
// - serial word: coding, channel, twelve result bits
// - sixteen output bits on falling clock edges
// - first six falling edges load control
// - later input bits ignored in frame
// - mode pin high parallel, low serial
// - select low enables reads and writes
// - write strobe latches address and control
// - short tx frame leaves control unchanged
`timescale 1ns/1ps
`default_nettype none
module adc_host_interface #(
  parameter int unsigned DATA_W     = adc_host_pkg::DATA_W,
  parameter int unsigned FIFO_DEPTH = adc_host_pkg::FIFO_DEPTH
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_mode,
  input  wire logic                    i_cs_n,
  input  wire logic                    i_rd_n,
  input  wire logic                    i_wr_n,
  input  wire logic [DATA_W-1:0]       i_pdata,
  output logic      [DATA_W-1:0]       o_pdata,
  output logic      [DATA_W-1:0]       o_pdata_oe,
  input  wire logic                    i_result_valid,
  input  wire logic [DATA_W-1:0]       i_result,
  output logic                         o_result_ready,
  output adc_host_pkg::acq_ctrl_t      o_ctrl,
  output logic                         o_ctrl_wr
);

  if (DATA_W != 12) begin : g_bad_width
    $error("adc_host_interface supports a 12-bit result only");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [adc_host_pkg::PIN_W-1:0] pin_s1_q;
  logic [adc_host_pkg::PIN_W-1:0] pin_s2_q;
  logic [adc_host_pkg::PIN_W-1:0] pin_p_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_s1_q <= 16'hffff;
      pin_s2_q <= 16'hffff;
      pin_p_q  <= 16'hffff;
    end else begin
      pin_s1_q <= {i_mode, i_cs_n, i_rd_n, i_wr_n, i_pdata};
      pin_s2_q <= pin_s1_q;
      pin_p_q  <= pin_s2_q;
    end
  end

  logic              mode_s;
  logic              cs_n_s;
  logic              rd_n_s;
  logic              wr_n_s;
  logic [DATA_W-1:0] data_s;
  logic [DATA_W-1:0] data_p;

  assign mode_s = pin_s2_q[adc_host_pkg::PIN_MODE];
  assign cs_n_s = pin_s2_q[adc_host_pkg::PIN_CS];
  assign rd_n_s = pin_s2_q[adc_host_pkg::PIN_RD];
  assign wr_n_s = pin_s2_q[adc_host_pkg::PIN_WR];
  assign data_s = pin_s2_q[DATA_W-1:0];
  assign data_p = pin_p_q[DATA_W-1:0];

  // ****************************************
  // edge detection
  // ****************************************
  logic serial;
  logic sclk_fall;
  logic tx_n_s;
  logic rx_n_s;
  logic tx_fall;
  logic tx_rise;
  logic rx_fall;
  logic rx_rise;
  logic din_s;
  logic rd_en;
  logic par_wr;

  assign serial    = ~mode_s;
  assign tx_n_s    = data_s[adc_host_pkg::LINE_TX_FR];
  assign rx_n_s    = data_s[adc_host_pkg::LINE_RX_FR];
  assign din_s     = data_s[adc_host_pkg::LINE_DIN];
  assign sclk_fall = serial & data_p[adc_host_pkg::LINE_SCLK]
                   & ~data_s[adc_host_pkg::LINE_SCLK];
  assign tx_fall   = serial & data_p[adc_host_pkg::LINE_TX_FR] & ~tx_n_s;
  assign tx_rise   = serial & ~data_p[adc_host_pkg::LINE_TX_FR] & tx_n_s;
  assign rx_fall   = serial & data_p[adc_host_pkg::LINE_RX_FR] & ~rx_n_s;
  assign rx_rise   = serial & ~data_p[adc_host_pkg::LINE_RX_FR] & rx_n_s;
  assign rd_en     = mode_s & ~cs_n_s & ~rd_n_s;
  // write lands on the rising strobe with the data seen while it was low
  assign par_wr    = mode_s & ~pin_p_q[adc_host_pkg::PIN_CS]
                   & ~pin_p_q[adc_host_pkg::PIN_WR] & wr_n_s;

  // ****************************************
  // result buffering
  // ****************************************
  logic              fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic              take;
  logic              fresh_q;
  logic [DATA_W-1:0] cur_q;
  logic              rd_act_q;
  logic              rx_act_q;
  logic [4:0]        rx_bits_q;
  logic              par_done;
  logic              ser_done;

  result_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (i_result_valid),
    .i_in_data   (i_result),
    .o_in_ready  (o_result_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (take)
  );

  // the held result never changes under a read in progress
  // a frame that opens in the same cycle must not see the word swapped under it
  assign take     = fifo_valid & ~fresh_q & ~rd_act_q & ~rd_en & ~rx_act_q & ~rx_fall;
  assign par_done = rd_act_q & ~rd_en;
  assign ser_done = rx_act_q & sclk_fall & ~rx_n_s & (rx_bits_q == adc_host_pkg::SER_LAST);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cur_q   <= 12'h000;
      fresh_q <= 1'b0;
    end else if (take) begin
      cur_q   <= fifo_data;
      fresh_q <= 1'b1;
    end else if (par_done || ser_done) begin
      fresh_q <= 1'b0;
    end
  end

  // ****************************************
  // control register
  // ****************************************
  adc_host_pkg::acq_ctrl_t ctrl_q;
  logic [4:0]              tx_sh_q;
  logic [2:0]              tx_bits_q;
  logic                    tx_act_q;
  logic                    ser_load;

  assign ser_load = tx_act_q & ~tx_n_s & sclk_fall & (tx_bits_q == adc_host_pkg::TX_LAST);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q    <= adc_host_pkg::CTRL_RESET;
      o_ctrl_wr <= 1'b0;
    end else begin
      o_ctrl_wr <= par_wr | ser_load;
      if (par_wr) begin
        ctrl_q.chan             <= data_p[adc_host_pkg::WR_CHAN_LSB +: 3];
        ctrl_q.soft_start_bit   <= data_p[adc_host_pkg::WR_START];
        ctrl_q.soft_standby_bit <= data_p[adc_host_pkg::WR_STANDBY];
        ctrl_q.twos_comp        <= data_p[adc_host_pkg::WR_CODING];
      end else if (ser_load) begin
        ctrl_q <= {tx_sh_q, din_s};
      end
    end
  end

  assign o_ctrl = ctrl_q;

  // ****************************************
  // serial control input
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_act_q  <= 1'b0;
      tx_bits_q <= 3'h0;
      tx_sh_q   <= 5'h00;
    end else if (tx_fall) begin
      tx_act_q  <= 1'b1;
      tx_bits_q <= 3'h0;
    end else if (tx_rise || mode_s) begin
      tx_act_q  <= 1'b0;
    end else if (tx_act_q && sclk_fall && tx_bits_q != adc_host_pkg::TX_FULL) begin
      tx_sh_q   <= {tx_sh_q[3:0], din_s};
      tx_bits_q <= tx_bits_q + 3'h1;
    end
  end

  // ****************************************
  // serial result output
  // ****************************************
  logic [adc_host_pkg::SER_WORD_W-1:0] rx_sh_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_act_q  <= 1'b0;
      rx_bits_q <= 5'h00;
      rx_sh_q   <= 16'h0000;
    end else if (rx_fall) begin
      rx_act_q  <= 1'b1;
      rx_bits_q <= 5'h00;
      rx_sh_q   <= {ctrl_q.twos_comp, ctrl_q.chan,
                    adc_host_pkg::code_result(cur_q, ctrl_q.twos_comp)};
    end else if (rx_rise || mode_s) begin
      rx_act_q  <= 1'b0;
    end else if (rx_act_q && sclk_fall) begin
      rx_sh_q   <= {rx_sh_q[14:0], 1'b0};
      rx_bits_q <= rx_bits_q + 5'h01;
      if (rx_bits_q == adc_host_pkg::SER_LAST) begin
        rx_act_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // data line drivers
  // ****************************************
  logic [DATA_W-1:0] out_q;
  logic [DATA_W-1:0] oe_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_act_q <= 1'b0;
    end else begin
      rd_act_q <= rd_en;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      oe_q <= 12'h000;
    end else if (mode_s) begin
      oe_q <= {DATA_W{rd_en}};
    end else begin
      // only the output line turns round in serial mode
      oe_q <= {11'h000, ~rx_n_s} << adc_host_pkg::LINE_DOUT;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_q <= 12'h000;
    end else if (mode_s) begin
      if (!rd_act_q) begin
        out_q <= adc_host_pkg::code_result(cur_q, ctrl_q.twos_comp);
      end
    end else begin
      out_q <= {11'h000, rx_sh_q[15]} << adc_host_pkg::LINE_DOUT;
    end
  end

  assign o_pdata    = out_q;
  assign o_pdata_oe = oe_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_par_write;
    mode_s && !pin_p_q[adc_host_pkg::PIN_CS] && !pin_p_q[adc_host_pkg::PIN_WR] && wr_n_s;
  endsequence

  sequence s_tx_edge;
    tx_act_q && !tx_n_s && sclk_fall;
  endsequence

  AST_OE_NEEDS_READ: assert property (
    (o_pdata_oe != 12'h000 && mode_s) |-> $past(rd_en)
  ) else $error("data lines driven without select and read");

  AST_READ_CODED: assert property (
    $rose(rd_act_q) |-> o_pdata == adc_host_pkg::code_result($past(cur_q), $past(ctrl_q.twos_comp))
  ) else $error("parallel read word wrong");

  AST_READ_HOLD: assert property (
    rd_act_q && rd_en && mode_s |=> $stable(o_pdata)
  ) else $error("read data changed during read");

  AST_PAR_WRITE: assert property (
    s_par_write |=> o_ctrl == $past(data_p[5:0])
  ) else $error("parallel write not stored");

  AST_SER_LOAD: assert property (
    s_tx_edge ##0 (tx_bits_q == 3'h5) |=> o_ctrl == {$past(tx_sh_q), $past(din_s)} && o_ctrl_wr
  ) else $error("serial control load wrong");

  AST_SER_IGNORE: assert property (
    s_tx_edge ##0 (tx_bits_q == 3'h6) && !par_wr |=> $stable(o_ctrl)
  ) else $error("control changed after six bits");

  AST_SER_SHORT: assert property (
    tx_rise && tx_act_q && tx_bits_q != 3'h6 && !par_wr |=> $stable(o_ctrl) [*2]
  ) else $error("short frame changed control");

  AST_SER_FIRST: assert property (
    rx_fall |=> rx_sh_q[15] == $past(ctrl_q.twos_comp) ##1 o_pdata[4] == $past(rx_sh_q[15])
  ) else $error("serial word does not open with coding bit");

  AST_SER_COUNT: assert property (
    rx_act_q && sclk_fall && !rx_n_s && !rx_rise |=> rx_bits_q == $past(rx_bits_q) + 5'h01
  ) else $error("serial bit count wrong");

  AST_MODE_SERIAL: assert property (
    !mode_s [*2] |-> (o_pdata_oe & 12'hfef) == 12'h000
  ) else $error("serial mode drove a non-output line");

endmodule
`default_nettype wire

// ===== rtl/adc_host_pkg.sv
package adc_host_pkg;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int unsigned DATA_W        = 12;
  localparam int unsigned CTRL_W        = 6;
  localparam int unsigned SER_WORD_W    = 16;
  localparam int unsigned SER_CTRL_BITS = 6;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned PIN_W         = 16;

  // ****************************************
  // synchronised pin vector layout
  // ****************************************
  localparam int unsigned PIN_MODE = 15;
  localparam int unsigned PIN_CS   = 14;
  localparam int unsigned PIN_RD   = 13;
  localparam int unsigned PIN_WR   = 12;

  // ****************************************
  // data line use in serial mode
  // ****************************************
  localparam int unsigned LINE_SCLK  = 0;
  localparam int unsigned LINE_TX_FR = 1;
  localparam int unsigned LINE_RX_FR = 2;
  localparam int unsigned LINE_DIN   = 3;
  localparam int unsigned LINE_DOUT  = 4;

  // ****************************************
  // data line use on a parallel write
  // ****************************************
  localparam int unsigned WR_CHAN_LSB = 3;
  localparam int unsigned WR_START    = 2;
  localparam int unsigned WR_STANDBY  = 1;
  localparam int unsigned WR_CODING   = 0;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  localparam logic [4:0]        SER_LAST   = 5'h0f;
  localparam logic [2:0]        TX_LAST    = 3'h5;
  localparam logic [2:0]        TX_FULL    = 3'h6;

  // bit order matches the register: chan msb first, coding lsb
  typedef struct packed {
    logic [2:0] chan;
    logic       soft_start_bit;
    logic       soft_standby_bit;
    logic       twos_comp;
  } acq_ctrl_t;

  // two's complement of an offset-binary code is its msb inverted
  function automatic logic [DATA_W-1:0] code_result(input logic [DATA_W-1:0] raw,
                                                    input logic              twos);
    code_result = twos ? {~raw[DATA_W-1], raw[DATA_W-2:0]} : raw;
  endfunction

endpackage

// ===== rtl/result_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int unsigned W     = 12,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic      [W-1:0] o_out_data,
  input  wire logic         i_out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("result_fifo depth must be a power of two of at least 2");
  end

  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   cnt_q;
  logic          vld_q;
  logic          push;
  logic          load;

  // the output register holds one word beyond the memory
  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign push        = i_in_valid & o_in_ready;
  assign load        = (cnt_q != '0) & (~vld_q | i_out_ready);
  assign o_out_valid = vld_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (load) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vld_q <= 1'b0;
    end else if (load) begin
      vld_q <= 1'b1;
    end else if (i_out_ready) begin
      vld_q <= 1'b0;
    end
  end

  result_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .i_core_clk (i_core_clk),
    .i_wr_en    (push),
    .i_wr_addr  (wr_ptr_q),
    .i_wr_data  (i_in_data),
    .i_rd_en    (load),
    .i_rd_addr  (rd_ptr_q),
    .o_rd_data  (o_out_data)
  );

endmodule
`default_nettype wire

// ===== rtl/result_mem.sv
`timescale 1ns/1ps
`default_nettype none
module result_mem #(
  parameter int unsigned W     = 12,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_wr_en,
  input  wire logic [AW-1:0] i_wr_addr,
  input  wire logic [W-1:0]  i_wr_data,
  input  wire logic          i_rd_en,
  input  wire logic [AW-1:0] i_rd_addr,
  output logic      [W-1:0]  o_rd_data
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge i_core_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule
`default_nettype wire

// ===== testbench/adc_host_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end
module adc_host_interface_tb;
  logic                     core_clk  = 1'b0;
  logic                     resetn    = 1'b0;
  logic                     mode;
  logic                     cs_n;
  logic                     rd_n;
  logic                     wr_n;
  logic [11:0]              line;
  logic [11:0]              dout;
  logic [11:0]              oe;
  logic                     res_valid = 1'b0;
  logic [11:0]              res_data  = 12'h000;
  logic                     res_ready;
  adc_host_pkg::acq_ctrl_t  ctrl;
  logic                     ctrl_wr;
  int                       n_fail      = 0;
  int                       comparisons = 0;
  int                       n_wr        = 0;

  always #2 core_clk = ~core_clk;

  always @(negedge core_clk) if (ctrl_wr === 1'b1) n_wr++;

  adc_host_interface u_adc_host_interface (
    .i_core_clk     (core_clk),
    .i_resetn       (resetn),
    .i_mode         (mode),
    .i_cs_n         (cs_n),
    .i_rd_n         (rd_n),
    .i_wr_n         (wr_n),
    .i_pdata        (line),
    .o_pdata        (dout),
    .o_pdata_oe     (oe),
    .i_result_valid (res_valid),
    .i_result       (res_data),
    .o_result_ready (res_ready),
    .o_ctrl         (ctrl),
    .o_ctrl_wr      (ctrl_wr)
  );

  host_model u_host_model (
    .i_core_clk (core_clk),
    .i_dev_data (dout),
    .i_dev_oe   (oe),
    .o_mode     (mode),
    .o_cs_n     (cs_n),
    .o_rd_n     (rd_n),
    .o_wr_n     (wr_n),
    .o_line     (line)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [11:0] enc(input logic [11:0] r, input logic t);
    return t ? (r ^ 12'h800) : r;
  endfunction

  task automatic push(input logic [11:0] raw);
    @(negedge core_clk);
    res_valid = 1'b1;
    res_data = raw;
    @(negedge core_clk);
    res_valid = 1'b0;
  endtask

  task automatic end_sim();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_par_write();
    logic [5:0] pats [4] = '{6'h29, 6'h16, 6'h3f, 6'h00};
    foreach (pats[i]) begin
      u_host_model.par_write(1'b0, {6'h2a, pats[i]});
      `CHECK(ctrl, pats[i])
    end
    `CHECK(n_wr, 4)
    u_host_model.par_write(1'b1, 12'h015);
    `CHECK(ctrl, 6'h00)
    `CHECK(n_wr, 4)
  endtask

  task automatic t_par_read();
    logic [11:0] d;
    logic [11:0] e;
    u_host_model.par_write(1'b0, 12'h018);
    push(12'h9a5);
    u_host_model.par_read(d, e);
    `CHECK(d, 12'h9a5)
    `CHECK(e, 12'hfff)
    `CHECK(oe, 12'h000)
    u_host_model.par_write(1'b0, 12'h019);
    push(12'h3c1);
    u_host_model.par_read(d, e);
    `CHECK(d, enc(12'h3c1, 1'b1))
  endtask

  // fill until the buffer refuses, then drain it in order
  task automatic t_fifo();
    logic [11:0] d;
    logic [11:0] e;
    int          n;
    n = 0;
    while (res_ready === 1'b1 && n < 24) begin
      push(12'h100 + n[11:0]);
      n++;
    end
    `CHECK(n >= 16, 1'b1)
    `CHECK(res_ready, 1'b0)
    push(12'hfff);
    for (int i = 0; i < n; i++) begin
      u_host_model.par_read(d, e);
      `CHECK(d, enc(12'h100 + i[11:0], 1'b1))
    end
    `CHECK(res_ready, 1'b1)
  endtask

  task automatic t_serial();
    logic [15:0] w;
    logic [11:0] e;
    u_host_model.set_mode(1'b0);
    u_host_model.par_write(1'b0, 12'h00f);
    `CHECK(ctrl, 6'h19)
    `CHECK(n_wr, 6)
    u_host_model.ser_frame(6'h2e, 8, 1'b0, w, e);
    `CHECK(ctrl, 6'h2e)
    u_host_model.ser_frame(6'h11, 5, 1'b0, w, e);
    `CHECK(ctrl, 6'h2e)
    `CHECK(n_wr, 7)
    push(12'h5a3);
    u_host_model.ser_frame(6'h07, 16, 1'b1, w, e);
    `CHECK(w, {1'b0, 3'h5, 12'h5a3})
    `CHECK(e, 12'h010)
    `CHECK(ctrl, 6'h07)
    push(12'h5a3);
    u_host_model.ser_frame(6'h07, 16, 1'b1, w, e);
    `CHECK(w, {1'b1, 3'h0, enc(12'h5a3, 1'b1)})
    `CHECK(n_wr, 9)
  endtask

  // ****************************************
  // sequence and watchdog
  // ****************************************
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHECK(ctrl, 6'h00)
    `CHECK(oe, 12'h000)
    `CHECK(res_ready, 1'b1)
    t_par_write();
    t_par_read();
    t_fifo();
    t_serial();
    end_sim();
  end

  // the whole run needs about 2.5k cycles; this leaves ample margin
  initial begin
    #200_000;
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire

// ===== testbench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        i_core_clk,
  input  wire logic [11:0] i_dev_data,
  input  wire logic [11:0] i_dev_oe,
  output logic             o_mode,
  output logic             o_cs_n,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic      [11:0] o_line
);
  logic [11:0] drv_en  = 12'h000;
  logic [11:0] drv_val = 12'h000;
  logic [11:0] last_q  = 12'h000;

  initial begin
    o_mode = 1'b1;
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
  end

  // ****************************************
  // line resolution
  // ****************************************
  // released lines flip every cycle, so a stale level never passes as data
  always_comb begin
    for (int b = 0; b < 12; b++) begin
      o_line[b] = i_dev_oe[b] ? i_dev_data[b] : (drv_en[b] ? drv_val[b] : ~last_q[b]);
    end
  end

  always @(posedge i_core_clk) last_q <= o_line;

  // ****************************************
  // host cycles
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  // serial idle: clock and both frames high, test lines low
  task automatic idle_lines();
    drv_val = 12'h007;
    drv_en  = o_mode ? 12'h000 : 12'h06f;
  endtask

  task automatic set_mode(input logic m);
    tick(1);
    o_mode = m;
    idle_lines();
    tick(8);
  endtask

  task automatic par_write(input logic cs_n, input logic [11:0] val);
    tick(1);
    drv_en = 12'hfff;
    drv_val = val;
    o_cs_n = cs_n;
    tick(2);
    o_wr_n = 1'b0;
    tick(4);
    o_wr_n = 1'b1;
    tick(4);
    o_cs_n = 1'b1;
    idle_lines();
    tick(8);
  endtask

  task automatic par_read(output logic [11:0] data, output logic [11:0] oe);
    tick(1);
    drv_en = 12'h000;
    o_cs_n = 1'b0;
    o_rd_n = 1'b0;
    tick(8);
    data = o_line;
    oe = i_dev_oe;
    o_rd_n = 1'b1;
    o_cs_n = 1'b1;
    tick(8);
  endtask

  // the serial clock only runs inside a frame
  task automatic ser_frame(input logic [5:0] ctrl, input int nclk, input logic rx,
                           output logic [15:0] word, output logic [11:0] oe);
    word = 16'h0000;
    oe = 12'h000;
    tick(1);
    drv_val[1] = 1'b0;
    drv_val[2] = ~rx;
    drv_val[3] = ctrl[5];
    tick(20);
    for (int k = 0; k < nclk; k++) begin
      word = {word[14:0], o_line[4]};
      oe = i_dev_oe;
      drv_val[0] = 1'b0;
      tick(20);
      drv_val[0] = 1'b1;
      drv_val[3] = (k < 5) ? ctrl[4-k] : k[0];
      tick(20);
    end
    drv_val[2:1] = 2'b11;
    tick(20);
  endtask
endmodule
`default_nettype wire
